// ### testbench/test_trigger_sequencer_step_commands.sv
module test_trigger_sequencer_step_commands;
  timeunit 1ns;
  timeprecision 1ns;
  import tss_pkg::*;

  logic        clock_i, srst_i, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, busy;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, trig, last_trig, rd_val;
  logic [1:0]  bresp, rresp, resp;
  logic [15:0] chsel;
  logic [7:0]  pulse_cnt;
  int          fails, samples_checked;
  // Copies, adds, reserved codes, then park on a software wait
  logic [7:0]  prog1 [16] = '{8'h18, 8'h19, 8'h1a, 8'h1b, 8'h1c, 8'h1d, 8'h10, 8'h11,
                              8'h12, 8'h13, 8'h14, 8'h15, 8'h16, 8'h1e, 8'h2f, 8'h0b};
  // Each effect but 02 (followed by the timer 1 wait 09) is followed by a software wait so it can be observed
  logic [7:0]  prog2 [16] = '{8'h0c, 8'h0b, 8'h0d, 8'h0b, 8'h0e, 8'h0b, 8'h0f, 8'h0b,
                              8'h08, 8'h0b, 8'h06, 8'h0b, 8'h02, 8'h09, 8'h0b, 8'h0b};

  tss_sequencer #(.QDEPTH(16), .LIM_W(16)) tss_sequencer_inst (
    .clock_i(clock_i), .srst_i(srst_i), .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
    .s_axi_awready_o(awready), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hf),
    .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
    .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready), .s_axi_araddr_i(araddr),
    .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
    .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
    .trig_o(trig), .adc_chsel_o(chsel), .busy_o(busy));

  tss_trig_sink tss_trig_sink_inst (
    .clock_i(clock_i), .srst_i(srst_i), .trig_i(trig), .pulse_cnt_o(pulse_cnt),
    .last_trig_o(last_trig));

  // 100 MHz sequencer clock
  initial
  begin
    clock_i = 1'h0;
    forever #5 clock_i = ~clock_i;
  end

  task automatic conclude();
    if (fails == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Address and data offered together; each dropped once taken
  // No cycle limit here: only the watchdog ends a stuck wait
  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clock_i);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'h1;
    wvalid  <= 1'h1;
    bready  <= 1'h1;
    do
    begin
      @(posedge clock_i);
      if (awvalid && awready) awvalid <= 1'h0;
      if (wvalid && wready) wvalid <= 1'h0;
    end
    while (!(bvalid && bready));
    resp = bresp;
    bready <= 1'h0;
  endtask

  task automatic axi_rd(input logic [11:0] a);
    @(posedge clock_i);
    araddr  <= a;
    arvalid <= 1'h1;
    rready  <= 1'h1;
    do
    begin
      @(posedge clock_i);
      if (arvalid && arready) arvalid <= 1'h0;
    end
    while (!(rvalid && rready));
    rd_val = rdata;
    resp   = rresp;
    rready <= 1'h0;
  endtask

  task automatic load(input logic [7:0] p [16]);
    for (int i = 0; i < 16; i++)
      axi_wr(ADDR_QUEUE + 12'(4 * i), {24'h0, p[i]});
  endtask

  // A software trigger rise: low then high, keeping the step delay bit
  task automatic rel(input logic sd);
    axi_wr(ADDR_CTRL, {29'h0, 1'h0, sd, 1'h1});
    axi_wr(ADDR_CTRL, {29'h0, 1'h1, sd, 1'h1});
  endtask

  // Poll status until the wanted state, then compare the whole word
  task automatic wait_st(input logic [2:0] st, input logic [3:0] pc);
    int n;
    n = 0;
    do
    begin
      axi_rd(ADDR_STATUS);
      n++;
    end
    while (rd_val[10:8] !== st && n < 60);
    chk("status", {19'h0, 1'h1, 1'h0, st, 4'h0, pc}, rd_val);
  endtask

  // Main sequence
  initial
  begin
    fails = 0;
    samples_checked = 0;
    srst_i = 1'h1;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
    awaddr = 12'h0;
    araddr = 12'h0;
    wdata = 32'h0;
    repeat (5) @(posedge clock_i);
    srst_i <= 1'h0;
    axi_wr(12'h0f0, 32'h1);
    chk("bresp", {30'h0, RESP_SLVERR}, {30'h0, resp});
    axi_rd(12'h0f0);
    chk("rresp", {30'h0, RESP_SLVERR}, {30'h0, resp});
    axi_wr(ADDR_ADJ, 32'h3);
    axi_wr(ADDR_HOLD, 32'h20);
    load(prog1);
    axi_wr(ADDR_CTRL, 32'h1);
    wait_st(3'h4, 4'hf);
    chk("busy", 32'h1, {31'h0, busy});
    for (int k = 0; k < LIM_NUM; k++)
    begin
      axi_rd(ADDR_LIM0 + 12'(4 * k));
      chk("limit", 32'h23, rd_val);
    end
    chk("chsel", 32'h0, {16'h0, chsel});
    chk("pulses", 32'h0, {24'h0, pulse_cnt});
    axi_wr(ADDR_CTRL, 32'h0);
    axi_wr(ADDR_CNT0, 32'h11);
    chk("busy", 32'h0, {31'h0, busy});
    axi_wr(ADDR_CNT1, 32'h22);
    axi_wr(ADDR_BTE, 32'h8000_0005);
    load(prog2);
    axi_wr(ADDR_CTRL, 32'h1);
    wait_st(3'h4, 4'h1);
    chk("chsel", 32'h11, {16'h0, chsel});
    rel(1'h0);
    wait_st(3'h4, 4'h3);
    chk("chsel", 32'h22, {16'h0, chsel});
    rel(1'h0);
    wait_st(3'h4, 4'h5);
    chk("chsel", 32'h23, {16'h0, chsel});
    rel(1'h0);
    wait_st(3'h4, 4'h7);
    chk("pulses", 32'h1, {24'h0, pulse_cnt});
    chk("trig", 32'h8000_0005, last_trig);
    rel(1'h0);
    axi_rd(ADDR_STATUS);
    chk("status", 32'h1208, rd_val);
    wait_st(3'h4, 4'h9);
    rel(1'h0);
    axi_rd(ADDR_STATUS);
    chk("state", 32'h5, {29'h0, rd_val[10:8]});
    wait_st(3'h4, 4'hb);
    axi_rd(ADDR_CTRL);
    chk("ctrl", 32'h7, rd_val);
    rel(1'h1);
    wait_st(3'h3, 4'hd);
    wait_st(3'h4, 4'he);
    axi_rd(ADDR_CTRL);
    chk("ctrl", 32'h5, rd_val);
    rel(1'h0);
    wait_st(3'h4, 4'hf);
    repeat (20) @(posedge clock_i);
    wait_st(3'h4, 4'hf);
    rel(1'h0);
    wait_st(3'h4, 4'h1);
    conclude();
  end

  // Whole run needs a few hundred cycles; the watchdog fires after 10000
  initial
  begin
    #100000;
    fails++;
    conclude();
  end
endmodule

// ### testbench/tss_seq_chk.sv
module tss_seq_chk #(
  parameter int LIM_W = 16
) (
  input wire logic             clock_i,         // Sequencer clock
  input wire logic             srst_i,          // Synchronous reset
  input wire logic             s_axi_awvalid_i, // Write address valid
  input wire logic             s_axi_awready_o, // Write address ready
  input wire logic             s_axi_wvalid_i,  // Write data valid
  input wire logic             s_axi_wready_o,  // Write data ready
  input wire logic [1:0]       s_axi_bresp_o,   // Write response
  input wire logic             s_axi_bvalid_o,  // Write response valid
  input wire logic             s_axi_bready_i,  // Write response ready
  input wire logic             s_axi_arvalid_i, // Read address valid
  input wire logic             s_axi_arready_o, // Read address ready
  input wire logic [31:0]      s_axi_rdata_o,   // Read data
  input wire logic             s_axi_rvalid_o,  // Read data valid
  input wire logic             s_axi_rready_i,  // Read data ready
  input wire logic [31:0]      trig_o,          // Trigger pulses
  input wire logic [LIM_W-1:0] adc_chsel_o,     // ADC channel select
  input wire logic             busy_o           // Sequence running
);
  timeunit 1ns;
  timeprecision 1ns;

  // One domain, so clock and reset are given once
  default clocking @(posedge clock_i); endclocking
  default disable iff (srst_i);

  bresp_hold_a:
    assert property (s_axi_bvalid_o && !s_axi_bready_i
                     |=> s_axi_bvalid_o && $stable(s_axi_bresp_o))
    else $error("write response dropped before accept");
  rdata_hold_a:
    assert property (s_axi_rvalid_o && !s_axi_rready_i
                     |=> s_axi_rvalid_o && $stable(s_axi_rdata_o))
    else $error("read data dropped before accept");
  // Write lands one cycle after the take, so the answer shows two edges on
  wr_answer_a:
    assert property (s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o
                     |-> ##2 s_axi_bvalid_o)
    else $error("write response late");
  rd_answer_a:
    assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
    else $error("read data late");
  wr_refuse_a:
    assert property (s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o)
    else $error("write accepted while response pending");
  rd_refuse_a:
    assert property (s_axi_rvalid_o |-> !s_axi_arready_o)
    else $error("read accepted while data pending");
  ready_back_a:
    assert property (s_axi_bvalid_o && s_axi_bready_i |=> s_axi_awready_o && s_axi_wready_o)
    else $error("write channels not reopened");
  trig_busy_a:
    assert property (trig_o != 32'h0 |-> busy_o)
    else $error("trigger while sequencer idle");
  chsel_busy_a:
    assert property ($changed(adc_chsel_o) |-> busy_o)
    else $error("channel select moved while idle");
endmodule

bind tss_sequencer tss_seq_chk #(.LIM_W(LIM_W)) tss_seq_chk_inst (
  .clock_i(clock_i), .srst_i(srst_i), .s_axi_awvalid_i(s_axi_awvalid_i),
  .s_axi_awready_o(s_axi_awready_o), .s_axi_wvalid_i(s_axi_wvalid_i),
  .s_axi_wready_o(s_axi_wready_o), .s_axi_bresp_o(s_axi_bresp_o),
  .s_axi_bvalid_o(s_axi_bvalid_o), .s_axi_bready_i(s_axi_bready_i),
  .s_axi_arvalid_i(s_axi_arvalid_i), .s_axi_arready_o(s_axi_arready_o),
  .s_axi_rdata_o(s_axi_rdata_o), .s_axi_rvalid_o(s_axi_rvalid_o),
  .s_axi_rready_i(s_axi_rready_i), .trig_o(trig_o), .adc_chsel_o(adc_chsel_o),
  .busy_o(busy_o));

// ### testbench/tss_trig_sink.sv
module tss_trig_sink (
  input  wire logic        clock_i,     // Sequencer clock
  input  wire logic        srst_i,      // Synchronous reset
  input  wire logic [31:0] trig_i,      // Trigger pulses from the sequencer
  output logic      [7:0]  pulse_cnt_o, // Cycles with any trigger high
  output logic      [31:0] last_trig_o  // Last nonzero trigger word
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [7:0]  cnt_ff;
  logic [31:0] last_ff;

  // Peripherals act on every high cycle, so a stretched pulse counts twice
  always_ff @(posedge clock_i)
  begin
    if (srst_i)
    begin
      cnt_ff  <= 8'h0;
      last_ff <= 32'h0;
    end
    else if (trig_i != 32'h0)
    begin
      cnt_ff  <= cnt_ff + 8'h1;
      last_ff <= trig_i;
    end
  end

  // Observed counts for the bench
  assign pulse_cnt_o = cnt_ff;
  assign last_trig_o = last_ff;
endmodule

// ### verilog/tss_limit_timer.sv
module tss_limit_timer #(
  parameter int W = 16
) (
  input  wire logic         clock_i, // Sequencer clock
  input  wire logic         srst_i,  // Synchronous reset
  input  wire logic         start_i, // Restart count from zero
  input  wire logic [W-1:0] limit_i, // Match value
  output logic              match_o  // Running and equal to limit
);
  import tss_pkg::*;

  logic [W-1:0] count_ff;
  logic         run_ff;

  // Counts up from zero once started, stops at the limit
  always_ff @(posedge clock_i)
  begin
    if (srst_i)
    begin
      count_ff <= W'(RST_WORD);
      run_ff   <= 1'b0;
    end
    else if (start_i)
    begin
      count_ff <= W'(RST_WORD);
      run_ff   <= 1'b1;
    end
    else if (run_ff)
    begin
      if (count_ff == limit_i)
        run_ff <= 1'b0;
      else
        count_ff <= count_ff + W'(1);
    end
  end

  // Limit read live, so a bus write that edits it mid-wait still counts
  assign match_o = run_ff && (count_ff == limit_i);

endmodule

// ### verilog/tss_pkg.sv
package tss_pkg;

  // Register bus geometry
  localparam int          AXI_AW       = 12;
  localparam int          AXI_DW       = 32;

  // Byte addresses of the register map
  localparam logic [11:0] ADDR_CTRL    = 12'h000;
  localparam logic [11:0] ADDR_STATUS  = 12'h004;
  localparam logic [11:0] ADDR_BTE     = 12'h008;
  localparam logic [11:0] ADDR_ADJ     = 12'h00c;
  localparam logic [11:0] ADDR_HOLD    = 12'h010;
  localparam logic [11:0] ADDR_LIM0    = 12'h014; // six limit words follow
  localparam logic [11:0] ADDR_CNT0    = 12'h02c;
  localparam logic [11:0] ADDR_CNT1    = 12'h030;
  localparam logic [11:0] ADDR_CHSEL   = 12'h034;
  localparam logic [11:0] ADDR_QUEUE   = 12'h100; // one step per word

  // Control register fields
  localparam int          CTRL_EN_BIT   = 0;
  localparam int          CTRL_SDEN_BIT = 1;
  localparam int          CTRL_SWT_BIT  = 2;

  // Status register fields
  localparam int          STAT_PC_LSB   = 0;
  localparam int          STAT_ST_LSB   = 8;
  localparam int          STAT_BUSY_BIT = 12;

  // Step command byte: command in the high nibble, option in the low
  localparam logic [3:0]  CMD_CTRL     = 4'h0;
  localparam logic [3:0]  CMD_ADDCOP   = 4'h1;

  // Control step options
  localparam logic [3:0]  OPT_SD_OFF   = 4'h2;
  localparam logic [3:0]  OPT_SD_ON    = 4'h6;
  localparam logic [3:0]  OPT_T0_WAIT  = 4'h8;
  localparam logic [3:0]  OPT_T1_WAIT  = 4'h9;
  localparam logic [3:0]  OPT_SWT_WAIT = 4'hb;
  localparam logic [3:0]  OPT_CH_CNT0  = 4'hc;
  localparam logic [3:0]  OPT_CH_CNT1  = 4'hd;
  localparam logic [3:0]  OPT_CH_LIT0  = 4'he;
  localparam logic [3:0]  OPT_BCAST    = 4'hf;

  // Limit file index, also the low three option bits of add and copy
  localparam logic [2:0]  LIM_CNT0     = 3'h0;
  localparam logic [2:0]  LIM_CNT1     = 3'h1;
  localparam logic [2:0]  LIM_TMR0     = 3'h2;
  localparam logic [2:0]  LIM_TMR1     = 3'h3;
  localparam logic [2:0]  LIM_SDLY     = 3'h4;
  localparam logic [2:0]  LIM_LIT0     = 3'h5;
  localparam int          LIM_NUM      = 6;

  // Reset values
  localparam logic [31:0] RST_WORD     = 32'h0000_0000;
  localparam logic [7:0]  RST_STEP     = 8'h00;

  // Bus responses
  localparam logic [1:0]  RESP_OKAY    = 2'b00;
  localparam logic [1:0]  RESP_SLVERR  = 2'b10;

  typedef enum logic [2:0] {
    ST_IDLE     = 3'b000,
    ST_EXEC     = 3'b001,
    ST_WAIT_T0  = 3'b010,
    ST_WAIT_T1  = 3'b011,
    ST_WAIT_SWT = 3'b100,
    ST_DELAY    = 3'b101
  } tss_state_e;

endpackage

// ### verilog/tss_sequencer.sv
// Summary of operation
// - Reserved commands and options take a step but change nothing.
// - Control option 0010 turns the step delay off from its own step onward.
// - Control option 0110 turns the step delay on from its own step onward.
// - Control option 1000 starts timer 0 and holds until it meets its limit.
// - Control option 1001 starts timer 1 and holds until it meets its limit.
// - Control option 1011 holds until the software trigger bit rises.
// - Control option 1100 copies counter 0 into the ADC channel select.
// - Control option 1101 copies counter 1 into the ADC channel select.
// - Control option 1110 copies literal 0 into the ADC channel select.
// - Control option 1111 pulses every trigger enabled for broadcast.
// - Add options 0000 to 0101 add the adjust value to the chosen limit.
// - Copy options 1000 to 1101 load the hold value into the chosen limit.
//
// Design decisions made here: register access over AXI4-Lite and the register addresses.
module tss_sequencer #(
  parameter int QDEPTH = 16,
  parameter int LIM_W  = 16
) (
  input  wire logic                  clock_i,         // Sequencer clock
  input  wire logic                  srst_i,          // Synchronous reset
  input  wire logic [tss_pkg::AXI_AW-1:0] s_axi_awaddr_i,  // Write address
  input  wire logic                  s_axi_awvalid_i, // Write address valid
  output logic                       s_axi_awready_o, // Write address ready
  input  wire logic [31:0]           s_axi_wdata_i,   // Write data
  input  wire logic [3:0]            s_axi_wstrb_i,   // Write byte lanes
  input  wire logic                  s_axi_wvalid_i,  // Write data valid
  output logic                       s_axi_wready_o,  // Write data ready
  output logic [1:0]                 s_axi_bresp_o,   // Write response
  output logic                       s_axi_bvalid_o,  // Write response valid
  input  wire logic                  s_axi_bready_i,  // Write response ready
  input  wire logic [tss_pkg::AXI_AW-1:0] s_axi_araddr_i,  // Read address
  input  wire logic                  s_axi_arvalid_i, // Read address valid
  output logic                       s_axi_arready_o, // Read address ready
  output logic [31:0]                s_axi_rdata_o,   // Read data
  output logic [1:0]                 s_axi_rresp_o,   // Read response
  output logic                       s_axi_rvalid_o,  // Read data valid
  input  wire logic                  s_axi_rready_i,  // Read data ready
  output logic [31:0]                trig_o,          // Trigger pulses out
  output logic [LIM_W-1:0]           adc_chsel_o,     // ADC channel select
  output logic                       busy_o           // Sequence running
);
  import tss_pkg::*;

  localparam int PCW = $clog2(QDEPTH);
  localparam logic [AXI_AW-1:0] QEND = AXI_AW'(ADDR_QUEUE + 4 * QDEPTH);

  // Byte-lane merge for partial writes
  function automatic logic [31:0] merge_bytes(input logic [31:0] old,
                                              input logic [31:0] data,
                                              input logic [3:0]  strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++)
      if (strb[i])
        res[8*i +: 8] = data[8*i +: 8];
    return res;
  endfunction

  // Word-aligned and inside the map
  function automatic logic addr_mapped(input logic [AXI_AW-1:0] a);
    return (a[1:0] == 2'b00) &&
           ((a <= ADDR_CHSEL) || ((a >= ADDR_QUEUE) && (a < QEND)));
  endfunction

  // Limit file slot of a limit address
  function automatic logic [2:0] lim_index(input logic [AXI_AW-1:0] a);
    logic [AXI_AW-1:0] off;
    off = a - ADDR_LIM0;
    return off[4:2];
  endfunction

  function automatic logic is_lim(input logic [AXI_AW-1:0] a);
    return (a >= ADDR_LIM0) && (a < ADDR_CNT0);
  endfunction

  // Register state
  logic [7:0]        queue_mem [QDEPTH];
  logic [LIM_W-1:0]  lim_ff [LIM_NUM];
  logic [LIM_W-1:0]  cnt_ff [2];
  logic [31:0]       bte_ff;
  logic [LIM_W-1:0]  adj_ff;
  logic [LIM_W-1:0]  hold_ff;
  logic              en_ff;
  logic              sd_en_ff;
  logic              swt_ff;
  logic              swt_prev_ff;
  logic [LIM_W-1:0]  chsel_ff;
  logic [31:0]       trig_ff;

  // Sequencer state
  tss_state_e        state_ff;
  tss_state_e        nxt_state;
  logic [PCW-1:0]    pc_ff;

  // Bus slave state
  logic              awready_ff;
  logic              wready_ff;
  logic              bvalid_ff;
  logic [1:0]        bresp_ff;
  logic [AXI_AW-1:0] awaddr_ff;
  logic [31:0]       wdata_ff;
  logic [3:0]        wstrb_ff;
  logic              arready_ff;
  logic              rvalid_ff;
  logic [1:0]        rresp_ff;
  logic [31:0]       rdata_ff;

  // Step decode
  logic [7:0] step;
  logic [3:0] cmd;
  logic [3:0] opt;
  logic       in_ctrl;
  logic       in_addcop;
  logic       lim_hit;
  logic       sd_en_eff;
  logic       swt_rise;
  logic       t0_match;
  logic       t1_match;
  logic       sd_match;
  logic       step_done;
  logic       wait_step;
  logic       wr_fire;
  logic [31:0] rd_word;

  assign step      = queue_mem[pc_ff];
  assign cmd       = step[7:4];
  assign opt       = step[3:0];
  assign in_ctrl   = (state_ff == ST_EXEC) && (cmd == CMD_CTRL);
  assign in_addcop = (state_ff == ST_EXEC) && (cmd == CMD_ADDCOP);
  // Options 0110/0111 and 1110/1111 fall outside the file: no effect
  assign lim_hit   = in_addcop && (opt[2:0] < 3'(LIM_NUM));
  assign swt_rise  = swt_ff && !swt_prev_ff;
  assign wait_step = in_ctrl && ((opt == OPT_T0_WAIT) || (opt == OPT_T1_WAIT) ||
                                 (opt == OPT_SWT_WAIT));

  // New delay setting applies from the step that sets it onward
  always_comb
  begin
    sd_en_eff = sd_en_ff;
    if (in_ctrl && (opt == OPT_SD_OFF))
      sd_en_eff = 1'b0;
    else if (in_ctrl && (opt == OPT_SD_ON))
      sd_en_eff = 1'b1;
  end

  // Step completion, waits included
  always_comb
  begin
    case (state_ff)
      ST_EXEC:     step_done = !wait_step;
      ST_WAIT_T0:  step_done = t0_match;
      ST_WAIT_T1:  step_done = t1_match;
      ST_WAIT_SWT: step_done = swt_rise;
      default:     step_done = 1'b0;
    endcase
  end

  // Sequence flow; clearing enable aborts any wait
  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE:
        if (en_ff)
          nxt_state = ST_EXEC;
      ST_EXEC:
        if (in_ctrl && (opt == OPT_T0_WAIT))
          nxt_state = ST_WAIT_T0;
        else if (in_ctrl && (opt == OPT_T1_WAIT))
          nxt_state = ST_WAIT_T1;
        else if (in_ctrl && (opt == OPT_SWT_WAIT))
          nxt_state = ST_WAIT_SWT;
        else if (sd_en_eff)
          nxt_state = ST_DELAY;
      ST_WAIT_T0, ST_WAIT_T1, ST_WAIT_SWT:
        if (step_done)
          nxt_state = sd_en_ff ? ST_DELAY : ST_EXEC;
      ST_DELAY:
        if (sd_match)
          nxt_state = ST_EXEC;
      default:
        nxt_state = ST_IDLE;
    endcase
    if (!en_ff)
      nxt_state = ST_IDLE;
  end

  always_ff @(posedge clock_i)
  begin
    if (srst_i)
      state_ff <= ST_IDLE;
    else
      state_ff <= nxt_state;
  end

  // Queue pointer wraps after the last slot
  always_ff @(posedge clock_i)
  begin
    if (srst_i || !en_ff)
      pc_ff <= '0;
    else if (step_done)
      pc_ff <= pc_ff + PCW'(1);
  end

  // Timers and step delay share one counter design
  tss_limit_timer #(.W(LIM_W)) u_tmr0 (
    .clock_i (clock_i),
    .srst_i  (srst_i),
    .start_i (in_ctrl && (opt == OPT_T0_WAIT)),
    .limit_i (lim_ff[LIM_TMR0]),
    .match_o (t0_match)
  );

  tss_limit_timer #(.W(LIM_W)) u_tmr1 (
    .clock_i (clock_i),
    .srst_i  (srst_i),
    .start_i (in_ctrl && (opt == OPT_T1_WAIT)),
    .limit_i (lim_ff[LIM_TMR1]),
    .match_o (t1_match)
  );

  tss_limit_timer #(.W(LIM_W)) u_sdly (
    .clock_i (clock_i),
    .srst_i  (srst_i),
    .start_i (step_done && (nxt_state == ST_DELAY)),
    .limit_i (lim_ff[LIM_SDLY]),
    .match_o (sd_match)
  );

  // Write channel: address and data taken in either order
  assign wr_fire = !awready_ff && !wready_ff && !bvalid_ff;

  always_ff @(posedge clock_i)
  begin
    if (srst_i)
    begin
      awready_ff <= 1'b1;
      wready_ff  <= 1'b1;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= RESP_OKAY;
      awaddr_ff  <= '0;
      wdata_ff   <= RST_WORD;
      wstrb_ff   <= 4'h0;
    end
    else
    begin
      if (s_axi_awvalid_i && awready_ff)
      begin
        awready_ff <= 1'b0;
        awaddr_ff  <= s_axi_awaddr_i;
      end
      if (s_axi_wvalid_i && wready_ff)
      begin
        wready_ff <= 1'b0;
        wdata_ff  <= s_axi_wdata_i;
        wstrb_ff  <= s_axi_wstrb_i;
      end
      if (wr_fire)
      begin
        bvalid_ff <= 1'b1;
        bresp_ff  <= addr_mapped(awaddr_ff) ? RESP_OKAY : RESP_SLVERR;
      end
      else if (bvalid_ff && s_axi_bready_i)
      begin
        bvalid_ff  <= 1'b0;
        awready_ff <= 1'b1;
        wready_ff  <= 1'b1;
      end
    end
  end

  // Control bits; a delay step command overrides a same-cycle write
  always_ff @(posedge clock_i)
  begin
    if (srst_i)
    begin
      en_ff       <= 1'b0;
      sd_en_ff    <= 1'b0;
      swt_ff      <= 1'b0;
      swt_prev_ff <= 1'b0;
    end
    else
    begin
      swt_prev_ff <= swt_ff;
      if (wr_fire && (awaddr_ff == ADDR_CTRL) && wstrb_ff[0])
      begin
        en_ff    <= wdata_ff[CTRL_EN_BIT];
        sd_en_ff <= wdata_ff[CTRL_SDEN_BIT];
        swt_ff   <= wdata_ff[CTRL_SWT_BIT];
      end
      if (in_ctrl && ((opt == OPT_SD_OFF) || (opt == OPT_SD_ON)))
        sd_en_ff <= sd_en_eff;
    end
  end

  // Plain software registers
  always_ff @(posedge clock_i)
  begin
    if (srst_i)
    begin
      bte_ff  <= RST_WORD;
      adj_ff  <= LIM_W'(RST_WORD);
      hold_ff <= LIM_W'(RST_WORD);
      cnt_ff  <= '{default: LIM_W'(RST_WORD)};
    end
    else if (wr_fire)
    begin
      case (awaddr_ff)
        ADDR_BTE:  bte_ff    <= merge_bytes(bte_ff, wdata_ff, wstrb_ff);
        ADDR_ADJ:  adj_ff    <= LIM_W'(merge_bytes(32'(adj_ff), wdata_ff, wstrb_ff));
        ADDR_HOLD: hold_ff   <= LIM_W'(merge_bytes(32'(hold_ff), wdata_ff, wstrb_ff));
        ADDR_CNT0: cnt_ff[0] <= LIM_W'(merge_bytes(32'(cnt_ff[0]), wdata_ff, wstrb_ff));
        ADDR_CNT1: cnt_ff[1] <= LIM_W'(merge_bytes(32'(cnt_ff[1]), wdata_ff, wstrb_ff));
        default:   bte_ff    <= bte_ff;
      endcase
    end
  end

  // Limit file; a step edit wins over a same-cycle software write
  always_ff @(posedge clock_i)
  begin
    if (srst_i)
      lim_ff <= '{default: LIM_W'(RST_WORD)};
    else if (lim_hit)
    begin
      if (opt[3])
        lim_ff[opt[2:0]] <= hold_ff;
      else
        lim_ff[opt[2:0]] <= lim_ff[opt[2:0]] + adj_ff;
    end
    else if (wr_fire && is_lim(awaddr_ff))
      lim_ff[lim_index(awaddr_ff)] <=
        LIM_W'(merge_bytes(32'(lim_ff[lim_index(awaddr_ff)]), wdata_ff, wstrb_ff));
  end

  // Step queue, low byte of each word
  always_ff @(posedge clock_i)
  begin
    if (srst_i)
      queue_mem <= '{default: RST_STEP};
    else if (wr_fire && (awaddr_ff >= ADDR_QUEUE) && (awaddr_ff < QEND) && wstrb_ff[0])
      queue_mem[PCW'((awaddr_ff - ADDR_QUEUE) >> 2)] <= wdata_ff[7:0];
  end

  // ADC channel select, loaded only by control steps
  always_ff @(posedge clock_i)
  begin
    if (srst_i)
      chsel_ff <= LIM_W'(RST_WORD);
    else if (in_ctrl && (opt == OPT_CH_CNT0))
      chsel_ff <= cnt_ff[0];
    else if (in_ctrl && (opt == OPT_CH_CNT1))
      chsel_ff <= cnt_ff[1];
    else if (in_ctrl && (opt == OPT_CH_LIT0))
      chsel_ff <= lim_ff[LIM_LIT0];
  end

  // Broadcast: one-cycle pulse on every enabled trigger at once
  always_ff @(posedge clock_i)
  begin
    if (srst_i)
      trig_ff <= RST_WORD;
    else if (in_ctrl && (opt == OPT_BCAST))
      trig_ff <= bte_ff;
    else
      trig_ff <= RST_WORD;
  end

  // Read mux; unmapped words read zero with an error answer
  always_comb
  begin
    rd_word = RST_WORD;
    if (is_lim(s_axi_araddr_i))
      rd_word = 32'(lim_ff[lim_index(s_axi_araddr_i)]);
    else if ((s_axi_araddr_i >= ADDR_QUEUE) && (s_axi_araddr_i < QEND))
      rd_word = 32'(queue_mem[PCW'((s_axi_araddr_i - ADDR_QUEUE) >> 2)]);
    else
      case (s_axi_araddr_i)
        ADDR_CTRL:
        begin
          rd_word[CTRL_EN_BIT]   = en_ff;
          rd_word[CTRL_SDEN_BIT] = sd_en_ff;
          rd_word[CTRL_SWT_BIT]  = swt_ff;
        end
        ADDR_STATUS:
        begin
          rd_word[STAT_PC_LSB +: PCW] = pc_ff;
          rd_word[STAT_ST_LSB +: 3]   = state_ff;
          rd_word[STAT_BUSY_BIT]      = (state_ff != ST_IDLE);
        end
        ADDR_BTE:   rd_word = bte_ff;
        ADDR_ADJ:   rd_word = 32'(adj_ff);
        ADDR_HOLD:  rd_word = 32'(hold_ff);
        ADDR_CNT0:  rd_word = 32'(cnt_ff[0]);
        ADDR_CNT1:  rd_word = 32'(cnt_ff[1]);
        ADDR_CHSEL: rd_word = 32'(chsel_ff);
        default:    rd_word = RST_WORD;
      endcase
  end

  // Read channel: answer one cycle after the address is taken
  always_ff @(posedge clock_i)
  begin
    if (srst_i)
    begin
      arready_ff <= 1'b1;
      rvalid_ff  <= 1'b0;
      rresp_ff   <= RESP_OKAY;
      rdata_ff   <= RST_WORD;
    end
    else if (s_axi_arvalid_i && arready_ff)
    begin
      arready_ff <= 1'b0;
      rvalid_ff  <= 1'b1;
      rresp_ff   <= addr_mapped(s_axi_araddr_i) ? RESP_OKAY : RESP_SLVERR;
      rdata_ff   <= addr_mapped(s_axi_araddr_i) ? rd_word : RST_WORD;
    end
    else if (rvalid_ff && s_axi_rready_i)
    begin
      rvalid_ff  <= 1'b0;
      arready_ff <= 1'b1;
    end
  end

  // Busy is a flop loaded from the next state, so it matches the state register with no lag
  logic busy_ff;
  always_ff @(posedge clock_i)
  begin
    if (srst_i)
      busy_ff <= 1'b0;
    else
      busy_ff <= (nxt_state != ST_IDLE);
  end

  assign s_axi_awready_o = awready_ff;
  assign s_axi_wready_o  = wready_ff;
  assign s_axi_bvalid_o  = bvalid_ff;
  assign s_axi_bresp_o   = bresp_ff;
  assign s_axi_arready_o = arready_ff;
  assign s_axi_rvalid_o  = rvalid_ff;
  assign s_axi_rresp_o   = rresp_ff;
  assign s_axi_rdata_o   = rdata_ff;
  assign trig_o          = trig_ff;
  assign adc_chsel_o     = chsel_ff;
  assign busy_o          = busy_ff;

endmodule
